// file: core/aft_pkg.sv
// Constants shared by the front-end frame interpreter and its process tuner.
// Assumes a single 200 MHz core clock; all other clocks arrive as sampled levels.
package aft_pkg;

	// ----------------------------------------------------------------
	// Core clock
	// ----------------------------------------------------------------
	localparam int CORE_CLK_MHZ = 200;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_W = 16;
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 12;
	localparam int PAYLOAD_MSB = 7;
	localparam int PAYLOAD_LSB = 0;
	localparam int RW_BIT = 8;
	localparam int SAMPLE_MSB = 11;
	localparam int SAMPLE_LSB = 0;
	localparam int SAMPLE_W = 12;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_SET_ADDR = 4'h8;
	localparam logic [3:0] CMD_HIGH_BYTE = 4'hA;
	localparam logic [3:0] CMD_LOW_BYTE = 4'h9;
	localparam int CMD_TOP_BIT = 3;

	// ----------------------------------------------------------------
	// Indirect register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RX_CFG = 8'h01;
	localparam logic [7:0] ADDR_TX_CFG = 8'h02;
	localparam logic [7:0] ADDR_CLK_CFG = 8'h03;
	localparam logic [7:0] ADDR_LIMIT = 8'h18;
	localparam logic [7:0] ADDR_HYST = 8'h19;
	localparam logic [15:0] CLK_CFG_RST = 16'h0013;
	localparam logic [15:0] LIMIT_RST = 16'h03F4;
	localparam logic [15:0] HYST_RST = 16'h0006;
	localparam logic [15:0] CLK_CFG_MASK = 16'h003F;
	localparam logic [15:0] TUNER_MASK = 16'h0FFF;

	// ----------------------------------------------------------------
	// Fields
	// ----------------------------------------------------------------
	localparam int SEL_MSB = 4;
	localparam int SEL_LSB = 3;
	localparam logic [1:0] SEL_RX = 2'h2;
	localparam logic [1:0] SEL_TX = 2'h3;
	localparam int RDEN_BIT = 0;
	localparam int DYN_BIT = 0;
	localparam int GAIN_LSB = 1;
	localparam int GAIN_W = 4;
	localparam int TUNER_W = 12;

	// Gain code per low command bits; entry zero means unchanged.
	localparam logic [7:0][3:0] GAIN_MAP = {4'h8, 4'h7, 4'h6, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};

	// ----------------------------------------------------------------
	// Sample clock divider
	// ----------------------------------------------------------------
	localparam int ADC_DIV = 16;
	localparam int ADC_CNT_W = $clog2(ADC_DIV);
	localparam logic [ADC_CNT_W-1:0] ADC_LAST = 4'hF;

endpackage

// file: core/aft_tuner.sv
// Process tuner counter: counts reference ticks over one RC ramp.
// Assumes the ramp end and reference tick are synchronous one-cycle pulses.
`timescale 1ns/1ps
module aft_tuner (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_ref_tick,
	input wire logic i_ramp_done,
	input wire logic [11:0] i_limit,
	input wire logic [11:0] i_hyst,
	output logic o_tune_inc,
	output logic o_tune_dec
);
	typedef struct packed {
		logic [11:0] cnt;
		logic inc;
		logic dec;
	} aft_tuner_state_t;

	localparam logic [11:0] CNT_MAX = 12'hFFF;

	aft_tuner_state_t st;
	aft_tuner_state_t next_st;
	logic [12:0] low_sum;

	// ----------------------------------------------------------------
	// Counting and comparison
	// ----------------------------------------------------------------
	// Count ticks; at ramp end judge the count against the window.
	always_comb
	begin
		next_st = st;
		next_st.inc = 1'b0;
		next_st.dec = 1'b0;
		low_sum = {1'b0, st.cnt} + {1'b0, i_hyst};
		if (i_ramp_done)
		begin
			next_st.cnt = '0;
			if (st.cnt > i_limit)
				next_st.dec = 1'b1;
			else if (low_sum < {1'b0, i_limit})
				next_st.inc = 1'b1;
		end
		else if (i_ref_tick && st.cnt != CNT_MAX)
			next_st.cnt = st.cnt + 12'h001;
	end

	// Register the state.
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_tune_inc = st.inc;
	assign o_tune_dec = st.dec;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	tune_dec_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_ramp_done && st.cnt > i_limit |=> o_tune_dec && !o_tune_inc && st.cnt == 12'h000)
		else $error("Tuner failed to step down above the limit.");
	tune_inc_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_ramp_done && ({1'b0, st.cnt} + {1'b0, i_hyst}) < {1'b0, i_limit} |=> o_tune_inc)
		else $error("Tuner failed to step up below the hysteresis window.");
	tune_count_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!i_ramp_done && !i_ref_tick |=> st.cnt == $past(st.cnt))
		else $error("Tuner count moved without a reference tick.");

endmodule // aft_tuner

// file: core/aft_frame_core.sv
// Front-end frame interpreter with indirect register space and tuner clock select.
// Assumes frames, bus data and the three clock levels are synchronous to i_core_clk.
//
// Overview of operation
// - select field picks reference, receive or transmit clock.
// - receive clock selected after reset.
// - tuner counts selected reference clock cycles.
// - sample tick every sixteen clock cycles.
// - sample rate follows clock in 200ksps steps.
// - shared bidirectional bus with separate handshake lines.
// - each modem transfer is one 16-bit frame.
// - top bit zero means transmit data frame.
// - code 1000 loads address and direction.
// - write high byte into holding register only.
// - write low byte, then store holding value.
// - read returns addressed register upper byte.
// - read returns addressed register lower byte.
// - read byte commands load holding from register.
// - low byte command post-increments the address.
// - reads need the read enable bit set.
// - without read enable every access writes.
// - counter limit bounds the tuning range.
// - hysteresis sets the tuning window width.
// - dynamic gain applies only when enabled.
`timescale 1ns/1ps
module aft_frame_core #(
	parameter int REG_DEPTH = 32
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_frame_strobe,
	input wire logic [15:0] i_bus_data,
	output logic [15:0] o_bus_data,
	output logic o_bus_oe_n,
	input wire logic i_reference_clock,
	input wire logic i_receive_clock,
	input wire logic i_transmit_clock,
	input wire logic i_rc_ramp_done,
	output logic [11:0] o_tx_sample,
	output logic o_tx_sample_valid,
	output logic [3:0] o_predriver_gain,
	output logic o_tuner_ref_clock,
	output logic o_adc_sample_tick,
	output logic o_tune_inc,
	output logic o_tune_dec
);
	localparam int IDX_W = $clog2(REG_DEPTH);

	typedef struct packed {
		logic [REG_DEPTH-1:0][15:0] regs;
		logic [7:0] addr;
		logic rw_read;
		logic [15:0] hold;
		logic [15:0] bus_out;
		logic bus_drv;
		logic [11:0] tx_sample;
		logic tx_valid;
		logic [1:0] clk_sel;
		logic ref_lvl;
		logic rx_prev;
		logic [aft_pkg::ADC_CNT_W-1:0] adc_cnt;
		logic adc_tick;
	} aft_state_t;

	// Build the reset image of the whole state.
	function automatic aft_state_t init_state();
		aft_state_t s;
		s = '0;
		s.regs[aft_pkg::ADDR_CLK_CFG] = aft_pkg::CLK_CFG_RST;
		s.regs[aft_pkg::ADDR_LIMIT] = aft_pkg::LIMIT_RST;
		s.regs[aft_pkg::ADDR_HYST] = aft_pkg::HYST_RST;
		s.clk_sel = aft_pkg::SEL_RX;
		return s;
	endfunction

	localparam aft_state_t ST_RESET = init_state();

	// Return the sampled level of the clock that a select code names.
	function automatic logic pick_clock(input logic [1:0] sel, input logic r, input logic x,
		input logic t);
		logic lvl;
		lvl = r;
		if (sel == aft_pkg::SEL_RX)
			lvl = x;
		else if (sel == aft_pkg::SEL_TX)
			lvl = t;
		return lvl;
	endfunction

	aft_state_t st;
	aft_state_t next_st;
	logic [3:0] cmd;
	logic [7:0] payload;
	logic eff_read;
	logic mapped;
	logic [IDX_W-1:0] idx;
	logic [15:0] rd_val;
	logic [15:0] wr_val;
	logic dyn_en;
	logic [1:0] new_sel;
	logic src_lvl;
	logic new_lvl;
	logic ref_tick;
	logic rx_rise;
	logic reserved_cmd;

	// ----------------------------------------------------------------
	// Frame decode helpers
	// ----------------------------------------------------------------
	// Split the frame and resolve the addressed register.
	always_comb
	begin
		cmd = i_bus_data[aft_pkg::CMD_MSB:aft_pkg::CMD_LSB];
		payload = i_bus_data[aft_pkg::PAYLOAD_MSB:aft_pkg::PAYLOAD_LSB];
		eff_read = st.rw_read && st.regs[aft_pkg::ADDR_RX_CFG][aft_pkg::RDEN_BIT];
		mapped = {24'h000000, st.addr} < REG_DEPTH;
		idx = st.addr[IDX_W-1:0];
		rd_val = mapped ? st.regs[idx] : 16'h0000;
		wr_val = {st.hold[15:8], payload};
		if (st.addr == aft_pkg::ADDR_CLK_CFG)
			wr_val = wr_val & aft_pkg::CLK_CFG_MASK;
		else if (st.addr == aft_pkg::ADDR_LIMIT || st.addr == aft_pkg::ADDR_HYST)
			wr_val = wr_val & aft_pkg::TUNER_MASK;
		dyn_en = st.regs[aft_pkg::ADDR_TX_CFG][aft_pkg::DYN_BIT];
		reserved_cmd = cmd[aft_pkg::CMD_TOP_BIT] && cmd != aft_pkg::CMD_SET_ADDR
			&& cmd != aft_pkg::CMD_HIGH_BYTE && cmd != aft_pkg::CMD_LOW_BYTE;
	end

	// ----------------------------------------------------------------
	// Clock selection and dividers
	// ----------------------------------------------------------------
	// Levels of the current and the requested tuner clock sources.
	always_comb
	begin
		new_sel = st.regs[aft_pkg::ADDR_CLK_CFG][aft_pkg::SEL_MSB:aft_pkg::SEL_LSB];
		src_lvl = pick_clock(st.clk_sel, i_reference_clock, i_receive_clock,
			i_transmit_clock);
		new_lvl = pick_clock(new_sel, i_reference_clock, i_receive_clock, i_transmit_clock);
		ref_tick = src_lvl && !st.ref_lvl;
		rx_rise = i_receive_clock && !st.rx_prev;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Interpret one frame per strobe and advance clock logic.
	always_comb
	begin
		next_st = st;
		next_st.tx_valid = 1'b0;
		next_st.bus_drv = 1'b0;
		next_st.adc_tick = 1'b0;
		if (i_frame_strobe)
		begin
			if (!cmd[aft_pkg::CMD_TOP_BIT])
			begin
				next_st.tx_sample = i_bus_data[aft_pkg::SAMPLE_MSB:aft_pkg::SAMPLE_LSB];
				next_st.tx_valid = 1'b1;
				if (dyn_en && cmd[2:0] != 3'h0)
					next_st.regs[aft_pkg::ADDR_TX_CFG][aft_pkg::GAIN_LSB +: aft_pkg::GAIN_W] =
						aft_pkg::GAIN_MAP[cmd[2:0]];
			end
			else if (cmd == aft_pkg::CMD_SET_ADDR)
			begin
				next_st.addr = payload;
				next_st.rw_read = i_bus_data[aft_pkg::RW_BIT];
			end
			else if (cmd == aft_pkg::CMD_HIGH_BYTE)
			begin
				if (eff_read)
				begin
					next_st.hold = rd_val;
					next_st.bus_out = {8'h00, rd_val[15:8]};
					next_st.bus_drv = 1'b1;
				end
				else
					next_st.hold[15:8] = payload;
			end
			else if (cmd == aft_pkg::CMD_LOW_BYTE)
			begin
				if (eff_read)
				begin
					next_st.hold = rd_val;
					next_st.bus_out = {8'h00, rd_val[7:0]};
					next_st.bus_drv = 1'b1;
				end
				else
				begin
					next_st.hold[7:0] = payload;
					if (mapped)
						next_st.regs[idx] = wr_val;
				end
				next_st.addr = st.addr + 8'h01;
			end
			// Reserved codes fall through and leave everything as it was.
		end
		// Hold the tuner clock until the output and both sources are low, so the
		// last high phase of the old source has already left the pin.
		next_st.ref_lvl = src_lvl;
		if (new_sel != st.clk_sel && !st.ref_lvl && !src_lvl && !new_lvl)
			next_st.clk_sel = new_sel;
		// Sample tick every sixteenth receive clock edge; rate tracks the clock.
		next_st.rx_prev = i_receive_clock;
		if (rx_rise)
		begin
			next_st.adc_cnt = st.adc_cnt + 4'h1;
			if (st.adc_cnt == aft_pkg::ADC_LAST)
				next_st.adc_tick = 1'b1;
		end
	end

	// Register the state.
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
			st <= ST_RESET;
		else
			st <= next_st;
	end

	// ----------------------------------------------------------------
	// Tuner and outputs
	// ----------------------------------------------------------------
	aft_tuner u_tuner (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_ref_tick(ref_tick),
		.i_ramp_done(i_rc_ramp_done),
		.i_limit(st.regs[aft_pkg::ADDR_LIMIT][aft_pkg::TUNER_W-1:0]),
		.i_hyst(st.regs[aft_pkg::ADDR_HYST][aft_pkg::TUNER_W-1:0]),
		.o_tune_inc(o_tune_inc),
		.o_tune_dec(o_tune_dec)
	);

	// Drive the ports from state.
	assign o_bus_data = st.bus_out;
	assign o_bus_oe_n = !st.bus_drv;
	assign o_tx_sample = st.tx_sample;
	assign o_tx_sample_valid = st.tx_valid;
	assign o_predriver_gain = st.regs[aft_pkg::ADDR_TX_CFG][aft_pkg::GAIN_LSB +: aft_pkg::GAIN_W];
	assign o_tuner_ref_clock = st.ref_lvl;
	assign o_adc_sample_tick = st.adc_tick;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	clk_select_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		st.clk_sel == aft_pkg::SEL_RX |=> o_tuner_ref_clock == $past(i_receive_clock))
		else $error("Tuner clock does not follow the receive clock.");
	reset_select_a: assert property (@(posedge i_core_clk)
		i_sys_rst |=> st.clk_sel == aft_pkg::SEL_RX && !o_tuner_ref_clock)
		else $error("Tuner clock select is not receive clock after reset.");
	adc_divide_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		o_adc_sample_tick |-> $past(st.adc_cnt) == aft_pkg::ADC_LAST && st.adc_cnt == 4'h0)
		else $error("Sample tick not on the sixteenth edge.");
	tx_frame_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_frame_strobe && !cmd[aft_pkg::CMD_TOP_BIT]
		|=> o_tx_sample_valid && o_tx_sample == $past(i_bus_data[11:0]) && o_bus_oe_n)
		else $error("Data frame not passed to the transmit sample port.");
	addr_load_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_frame_strobe && cmd == aft_pkg::CMD_SET_ADDR
		|=> st.addr == $past(payload) && st.rw_read == $past(i_bus_data[aft_pkg::RW_BIT]))
		else $error("Address command did not load address and direction.");
	high_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_frame_strobe && cmd == aft_pkg::CMD_HIGH_BYTE && !eff_read
		|=> st.hold[15:8] == $past(payload) && $stable(st.regs) && $stable(st.addr))
		else $error("High byte write touched more than the holding register.");
	low_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_frame_strobe && cmd == aft_pkg::CMD_LOW_BYTE && !eff_read && mapped
		|=> st.regs[$past(idx)] == $past(wr_val) && st.hold[7:0] == $past(payload))
		else $error("Low byte write did not store the holding value.");
	addr_incr_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_frame_strobe && cmd == aft_pkg::CMD_LOW_BYTE |=> st.addr == $past(st.addr) + 8'h01)
		else $error("Address did not post-increment after a low byte command.");
	read_high_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_frame_strobe && cmd == aft_pkg::CMD_HIGH_BYTE && eff_read
		|=> !o_bus_oe_n && o_bus_data[7:0] == $past(rd_val[15:8]) ##1 o_bus_oe_n)
		else $error("High byte read not returned for exactly one cycle.");
	read_gate_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!st.regs[aft_pkg::ADDR_RX_CFG][aft_pkg::RDEN_BIT] |=> o_bus_oe_n)
		else $error("Bus driven while read mode is disabled.");
	reserved_cmd_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_frame_strobe && reserved_cmd
		|=> $stable(st.addr) && $stable(st.hold) && $stable(st.regs) && o_bus_oe_n)
		else $error("Reserved command changed device state.");
	gain_gate_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_frame_strobe && !cmd[aft_pkg::CMD_TOP_BIT] && !dyn_en |=> $stable(o_predriver_gain))
		else $error("Predriver gain changed while dynamic gain is off.");
	glitch_free_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		st.clk_sel != $past(st.clk_sel) |-> !o_tuner_ref_clock && !$past(o_tuner_ref_clock))
		else $error("Tuner clock source switched during a high phase.");

endmodule // aft_frame_core

// file: sim/aft_modem.sv
// Modem model: sends frames on the shared bus and makes the three source clocks.
// Assumes the caller sends one frame per call and calls idle to end a burst.
`timescale 1ns/1ps
module aft_modem (
	input wire logic i_core_clk,
	output logic o_frame_strobe,
	output logic [15:0] o_bus_data,
	output logic o_reference_clock,
	output logic o_receive_clock,
	output logic o_transmit_clock
);
	int div_cnt = 0;

	// Everything starts quiet so the first edge sees defined inputs.
	initial
	begin
		o_frame_strobe = 1'b0;
		o_bus_data = 16'h5A5A;
		o_reference_clock = 1'b0;
		o_receive_clock = 1'b0;
		o_transmit_clock = 1'b0;
	end

	// Source clocks run free at unrelated slow rates, so selection can be told apart.
	always @(posedge i_core_clk)
	begin
		div_cnt <= div_cnt + 1;
		if (div_cnt % 2 == 1)
			o_reference_clock <= ~o_reference_clock;
		if (div_cnt % 3 == 2)
			o_receive_clock <= ~o_receive_clock;
		if (div_cnt % 5 == 4)
			o_transmit_clock <= ~o_transmit_clock;
	end

	// One whole frame per call; the strobe stays raised until idle is called.
	task automatic send(input logic [15:0] frame);
		@(posedge i_core_clk);
		o_frame_strobe <= 1'b1;
		o_bus_data <= frame;
	endtask

	// A released bus shows a changing pattern, alternating between the last frame inverted and the last frame.
	task automatic idle();
		@(posedge i_core_clk);
		o_frame_strobe <= 1'b0;
		o_bus_data <= ~o_bus_data;
	endtask
endmodule // aft_modem

// file: sim/afe_frame_config_and_tuner_clock_tb.sv
// Self-checking bench for the frame interpreter, its registers, tuner and clocks.
// Assumes the modem model drives frames and the three source clocks.
`timescale 1ns/1ps
module afe_frame_config_and_tuner_clock_tb;
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_rc_ramp_done = 1'b0;
	logic strobe, ref_clk, rx_clk, tx_clk, o_bus_oe_n, o_tuner_ref_clock;
	logic o_adc_sample_tick, o_tx_sample_valid, o_tune_inc, o_tune_dec;
	logic [15:0] modem_data, o_bus_data, bus_wire;
	logic [11:0] o_tx_sample, smp;
	logic [3:0] o_predriver_gain, cur_gain;
	logic [15:0] exp_bus[$];
	logic [11:0] exp_smp[$];
	logic [3:0] gain_tab[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8};
	logic [1:0] exp_sel = 2'h2;
	logic chk_clk = 1'b0;
	logic rx_prev = 1'b0;
	logic prev_src = 1'b0;
	logic seen_tick = 1'b0;
	int rises = 0;
	int mismatches = 0;
	int samples_checked = 0;
	int seed = 98869;

	always #2.5 i_core_clk = ~i_core_clk;

	// The device drives the shared bus only while its enable is low.
	assign bus_wire = o_bus_oe_n ? modem_data : o_bus_data;

	aft_modem i_modem (.i_core_clk(i_core_clk), .o_frame_strobe(strobe),
		.o_bus_data(modem_data), .o_reference_clock(ref_clk),
		.o_receive_clock(rx_clk), .o_transmit_clock(tx_clk));

	aft_frame_core #(.REG_DEPTH(32)) i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_frame_strobe(strobe), .i_bus_data(bus_wire), .o_bus_data(o_bus_data),
		.o_bus_oe_n(o_bus_oe_n), .i_reference_clock(ref_clk), .i_receive_clock(rx_clk),
		.i_transmit_clock(tx_clk), .i_rc_ramp_done(i_rc_ramp_done),
		.o_tx_sample(o_tx_sample), .o_tx_sample_valid(o_tx_sample_valid),
		.o_predriver_gain(o_predriver_gain), .o_tuner_ref_clock(o_tuner_ref_clock),
		.o_adc_sample_tick(o_adc_sample_tick), .o_tune_inc(o_tune_inc),
		.o_tune_dec(o_tune_dec));

	// ----------------------------------------------------------------
	// Comparison and verdict
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watcher: answers and samples against the oldest note, plus clock relations.
	always @(posedge i_core_clk)
	begin
		if (!i_sys_rst)
		begin
			if (o_bus_oe_n !== 1'b1)
				check("read byte", o_bus_data, exp_bus.size() ? exp_bus.pop_front() : 16'hFFFF);
			if (o_tx_sample_valid !== 1'b0)
				check("tx sample", {4'h0, o_tx_sample}, exp_smp.size() ? {4'h0, exp_smp.pop_front()} : 16'hFFFF);
			if (o_adc_sample_tick === 1'b1)
			begin
				if (seen_tick)
					check("sample spacing", 16'(rises), 16'h0010);
				seen_tick <= 1'b1;
				rises <= int'(rx_clk && !rx_prev);
			end
			else
				rises <= rises + int'(rx_clk && !rx_prev);
			if (chk_clk)
				check("tuner clock", 16'(o_tuner_ref_clock), 16'(prev_src));
		end
		rx_prev <= rx_clk;
		prev_src <= exp_sel[1] ? (exp_sel[0] ? tx_clk : rx_clk) : ref_clk;
	end

	// ----------------------------------------------------------------
	// Frame sequences
	// ----------------------------------------------------------------
	// Address load, high byte, low byte; notes both answers when a read is expected.
	task automatic acc(input logic [7:0] addr, input logic rd, input logic [15:0] val,
		input bit ans);
		i_modem.send({4'h8, 3'h0, rd, addr});
		i_modem.send({4'hA, 4'h0, val[15:8]});
		if (ans)
			exp_bus.push_back({8'h00, val[15:8]});
		// The modem stays off the shared bus while a read answer may stand on it.
		i_modem.idle();
		i_modem.send({4'h9, 4'h0, val[7:0]});
		if (ans)
			exp_bus.push_back({8'h00, val[7:0]});
		i_modem.idle();
	endtask

	task automatic lo_rd(input logic [7:0] exp);
		i_modem.send(16'h9000);
		exp_bus.push_back({8'h00, exp});
		i_modem.idle();
	endtask

	task automatic ramp();
		@(posedge i_core_clk);
		i_rc_ramp_done <= 1'b1;
		@(posedge i_core_clk);
		i_rc_ramp_done <= 1'b0;
	endtask

	// Clears the count, lets gap cycles pass, then judges and collects the pulses.
	task automatic tune(input int gap, input logic [1:0] exp);
		logic [1:0] seen;
		seen = 2'b00;
		ramp();
		repeat (gap) @(posedge i_core_clk);
		ramp();
		repeat (4)
		begin
			@(posedge i_core_clk);
			seen = seen | {o_tune_inc, o_tune_dec};
		end
		check("tune pulses", {14'h0, seen}, {14'h0, exp});
	endtask

	// Main sequence: reset, registers, reserved codes, clock select, data, tuner.
	initial
	begin
		repeat (20) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		chk_clk <= 1'b1;
		repeat (40) @(posedge i_core_clk);
		chk_clk <= 1'b0;
		acc(8'h19, 1'b1, 16'hF005, 0);
		acc(aft_pkg::ADDR_RX_CFG, 1'b0, 16'h0001, 0);
		acc(8'h03, 1'b1, 16'h0013, 1);
		acc(8'h18, 1'b1, 16'h03F4, 1);
		lo_rd(8'h05);
		i_modem.send(16'h8103);
		for (int c = 11; c < 16; c++)
			i_modem.send({c[3:0], 12'($random(seed))});
		lo_rd(8'h13);
		for (int c = 0; c < 4; c++)
		begin
			acc(8'h03, 1'b0, {8'hFF, 3'h0, c[1:0], 3'h3}, 0);
			exp_sel <= c[1:0];
			repeat (30) i_modem.idle();
			chk_clk <= 1'b1;
			repeat (60) @(posedge i_core_clk);
			chk_clk <= 1'b0;
		end
		acc(aft_pkg::ADDR_TX_CFG, 1'b0, 16'h000A, 0);
		cur_gain = 4'h5;
		for (int n = 0; n < 16; n++)
		begin
			if (n == 8)
			begin
				acc(aft_pkg::ADDR_TX_CFG, 1'b0, 16'h0001, 0);
				cur_gain = 4'h0;
			end
			smp = 12'($random(seed));
			i_modem.send({1'b0, n[2:0], smp});
			exp_smp.push_back(smp);
			i_modem.idle();
			if (n >= 8 && n[2:0] != 3'h0)
				cur_gain = gain_tab[n[2:0]];
			@(negedge i_core_clk);
			check("gain", {12'h0, o_predriver_gain}, {12'h0, cur_gain});
		end
		for (int n = 0; n < 4; n++)
		begin
			smp = 12'($random(seed));
			i_modem.send({4'h0, smp});
			exp_smp.push_back(smp);
		end
		i_modem.idle();
		acc(8'h18, 1'b0, 16'h0014, 0);
		acc(8'h19, 1'b0, 16'h0004, 0);
		acc(8'h03, 1'b0, 16'h0000, 0);
		exp_sel <= 2'h0;
		tune(160, 2'b01);
		tune(40, 2'b10);
		tune(72, 2'b00);
		results();
	end

	// Watchdog well beyond the fewer than one thousand cycles the sequence needs.
	initial
	begin
		#200000;
		mismatches++;
		results();
	end
endmodule // afe_frame_config_and_tuner_clock_tb
